// [common/dual_watchdog_pkg.sv]
package dual_watchdog_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_KEY    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PSC    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h08;
   localparam logic [ADDR_W-1:0] WIN_BASE   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h14;
   // ----------------------------------------
   // keys, reset values, field positions
   // ----------------------------------------
   localparam logic [15:0] KEY_UNLOCK  = 16'h5555;
   localparam logic [15:0] KEY_REFRESH = 16'haaaa;
   localparam logic [15:0] KEY_START   = 16'hcccc;
   localparam logic [2:0]  PSC_RST     = 3'h6;
   localparam logic [7:0]  RELOAD_RST  = 8'hff;
   localparam logic [6:0]  WCOUNT_RST  = 7'h7f;
   localparam logic [6:0]  WINDOW_RST  = 7'h7f;
   localparam logic [6:0]  WFIRE_AT    = 7'h40;
   localparam int          WEN_BIT     = 7;
   localparam int          CNT_TOP_BIT = 6;
   localparam logic [8:0]  DIV_BASE    = 9'h004;
   localparam logic [2:0]  PSC_MAXCODE = 3'h6;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // master clock cycles per windowed decrement
   localparam int WDIV_CYCLES = 12288;

   typedef enum {SEL_KEY, SEL_PSC, SEL_RELOAD, SEL_CTRL, SEL_WINDOW, SEL_NONE} regSel_t;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } axiReq_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } axiRsp_t;
endpackage

// [design/dual_watchdog_registers.sv]
module dual_watchdog_registers #(
   parameter int WDIV = dual_watchdog_pkg::WDIV_CYCLES
) (
   // clock and resets
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  standbyReset,
   // register bus
   input  wire dual_watchdog_pkg::axiReq_t axiReq,
   output      dual_watchdog_pkg::axiRsp_t axiRsp,
   // low-speed clock and option strap
   input  wire logic                  lowSpeedClock,
   input  wire logic                  hwDogSelect,
   // reset requests
   output      logic                  keyDogResetReq,
   output      logic                  winDogResetReq
);
   import dual_watchdog_pkg::*;

   axiRsp_t           rsp_r;
   logic              awHeld_r, wHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [DATA_W-1:0] wData_r;
   logic [3:0]        wStrb_r;
   logic              lsMeta_r, lsSync_r, lsPrev_r;
   logic              hwMeta_r, hwSync_r;
   logic              unlocked_r, kEnable_r, kReset_r;
   logic [2:0]        psc_r;
   logic [7:0]        reload_r, kCount_r, kDiv_r;
   logic [6:0]        wCount_r, window_r;
   logic              wEnable_r, wReset_r;
   logic [13:0]       wDiv_r;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic regSel_t decode(input logic [ADDR_W-1:0] a);
      unique case (a)
         OFS_KEY:    decode = SEL_KEY;
         OFS_PSC:    decode = SEL_PSC;
         OFS_RELOAD: decode = SEL_RELOAD;
         OFS_CTRL:   decode = SEL_CTRL;
         OFS_WINDOW: decode = SEL_WINDOW;
         default:    decode = SEL_NONE;
      endcase
   endfunction

   function automatic logic [7:0] divLast(input logic [2:0] code);
      logic [2:0] c;
      logic [8:0] d;
      c = (code > PSC_MAXCODE) ? PSC_MAXCODE : code;
      d = (DIV_BASE << c) - 9'h001;
      divLast = d[7:0];
   endfunction

   // ----------------------------------------
   // bus write channels
   // ----------------------------------------
   logic    awTake, wTake, doWrite, bvalidNxt, awHeldNxt, wHeldNxt;
   regSel_t wrSel;
   assign awTake    = axiReq.awvalid && rsp_r.awready;
   assign wTake     = axiReq.wvalid && rsp_r.wready;
   assign doWrite   = awHeld_r && wHeld_r && !rsp_r.bvalid;
   assign bvalidNxt = doWrite || (rsp_r.bvalid && !axiReq.bready);
   assign awHeldNxt = (awHeld_r || awTake) && !doWrite;
   assign wHeldNxt  = (wHeld_r || wTake) && !doWrite;
   assign wrSel     = decode(awAddr_r);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= '0;
         wData_r  <= '0;
         wStrb_r  <= '0;
      end else begin
         awHeld_r <= awHeldNxt;
         wHeld_r  <= wHeldNxt;
         if (awTake) begin
            awAddr_r <= axiReq.awaddr;
         end
         if (wTake) begin
            wData_r <= axiReq.wdata;
            wStrb_r <= axiReq.wstrb;
         end
      end
   end

   // ----------------------------------------
   // bus response and read channels
   // ----------------------------------------
   logic    arTake, rvalidNxt;
   regSel_t rdSel;
   assign arTake    = axiReq.arvalid && rsp_r.arready;
   assign rvalidNxt = arTake || (rsp_r.rvalid && !axiReq.rready);
   assign rdSel     = decode(axiReq.araddr);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsp_r <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
      end else begin
         rsp_r.awready <= !awHeldNxt && !bvalidNxt;
         rsp_r.wready  <= !wHeldNxt && !bvalidNxt;
         rsp_r.bvalid  <= bvalidNxt;
         if (doWrite) begin
            rsp_r.bresp <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         rsp_r.arready <= !rvalidNxt;
         rsp_r.rvalid  <= rvalidNxt;
         if (arTake) begin
            rsp_r.rresp <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (rdSel)
               SEL_KEY:    rsp_r.rdata <= '0;
               SEL_PSC:    rsp_r.rdata <= {29'h0, psc_r};
               SEL_RELOAD: rsp_r.rdata <= {24'h0, reload_r};
               SEL_CTRL:   rsp_r.rdata <= {24'h0, wEnable_r, wCount_r};
               SEL_WINDOW: rsp_r.rdata <= {25'h0, window_r};
               SEL_NONE:   rsp_r.rdata <= '0;
            endcase
         end
      end
   end
   assign axiRsp = rsp_r;

   // ----------------------------------------
   // write events
   // ----------------------------------------
   logic keyWr, unlockKey, refreshKey, startKey, pscWr, reloadWr, ctrlWr, windowWr;
   assign keyWr      = doWrite && wrSel == SEL_KEY && wStrb_r[1:0] == 2'h3;
   assign unlockKey  = keyWr && wData_r[15:0] == KEY_UNLOCK;
   assign refreshKey = keyWr && wData_r[15:0] == KEY_REFRESH;
   assign startKey   = keyWr && wData_r[15:0] == KEY_START;
   assign pscWr      = doWrite && wrSel == SEL_PSC && wStrb_r[0] && unlocked_r;
   assign reloadWr   = doWrite && wrSel == SEL_RELOAD && wStrb_r[0] && unlocked_r;
   assign ctrlWr     = doWrite && wrSel == SEL_CTRL && wStrb_r[0];
   assign windowWr   = doWrite && wrSel == SEL_WINDOW && wStrb_r[0];

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // low-speed clock sampled as input
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lsMeta_r <= 1'b0;
         lsSync_r <= 1'b0;
         lsPrev_r <= 1'b0;
         hwMeta_r <= 1'b0;
         hwSync_r <= 1'b0;
      end else begin
         lsMeta_r <= lowSpeedClock;
         lsSync_r <= lsMeta_r;
         lsPrev_r <= lsSync_r;
         hwMeta_r <= hwDogSelect;
         hwSync_r <= hwMeta_r;
      end
   end

   logic lsRise, kTick, kFire;
   assign lsRise = lsSync_r && !lsPrev_r;
   assign kTick  = lsRise && kEnable_r && kDiv_r >= divLast(psc_r);
   assign kFire  = kTick && kCount_r == 8'h00;

   // ----------------------------------------
   // key-protected configuration
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unlocked_r <= 1'b0;
         reload_r   <= RELOAD_RST;
         psc_r      <= PSC_RST;
      end else if (standbyReset) begin
         unlocked_r <= 1'b0;
         reload_r   <= RELOAD_RST;
      end else begin
         if (unlockKey) begin
            unlocked_r <= 1'b1;
         end else if (refreshKey) begin
            unlocked_r <= 1'b0;
         end
         if (reloadWr) begin
            reload_r <= wData_r[7:0];
         end
         if (pscWr) begin
            psc_r <= wData_r[2:0];
         end
      end
   end

   // ----------------------------------------
   // key-protected counter
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         kEnable_r <= 1'b0;
         kCount_r  <= RELOAD_RST;
         kDiv_r    <= '0;
         kReset_r  <= 1'b0;
      end else begin
         if (startKey || hwSync_r) begin
            kEnable_r <= 1'b1;
         end
         if (lsRise && kEnable_r) begin
            kDiv_r <= (kDiv_r >= divLast(psc_r)) ? 8'h00 : kDiv_r + 8'h01;
         end
         // refresh reloads / from reload value
         if (refreshKey || kFire) begin
            kCount_r <= reload_r;
         end else if (kTick) begin
            kCount_r <= kCount_r - 8'h01;
         end
         if (kFire) begin
            kReset_r <= 1'b1;
         end else if (lsRise) begin
            kReset_r <= 1'b0;
         end
      end
   end
   assign keyDogResetReq = kReset_r;

   // ----------------------------------------
   // windowed dog
   // ----------------------------------------
   logic wTick, wFire, wEnNow;
   assign wTick  = wDiv_r == 14'(WDIV - 1);
   assign wEnNow = wEnable_r || (ctrlWr && wData_r[WEN_BIT]);
   // 0x40 to 0x3f / early reload / gated
   assign wFire  = (wEnable_r && wTick && !ctrlWr && wCount_r == WFIRE_AT)
                || (ctrlWr && wEnNow && (wCount_r > window_r || !wData_r[CNT_TOP_BIT]));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wDiv_r    <= '0;
         wCount_r  <= WCOUNT_RST;
         window_r  <= WINDOW_RST;
         wEnable_r <= 1'b0;
         wReset_r  <= 1'b0;
      end else begin
         wDiv_r <= wTick ? 14'h0000 : wDiv_r + 14'h0001;
         if (ctrlWr) begin
            wCount_r <= wData_r[6:0];
         end else if (wTick) begin
            wCount_r <= wCount_r - 7'h01;
         end
         if (ctrlWr && wData_r[WEN_BIT]) begin
            wEnable_r <= 1'b1;
         end
         if (windowWr) begin
            window_r <= wData_r[6:0];
         end
         wReset_r <= wFire;
      end
   end
   assign winDogResetReq = wReset_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic rdKey_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdKey_r <= 1'b0;
      end else if (arTake) begin
         rdKey_r <= rdSel == SEL_KEY;
      end
   end

   sequence refreshSeq;
      refreshKey && !standbyReset;
   endsequence
   sequence loadedSeq;
      ##1 kCount_r == $past(reload_r);
   endsequence

   chk_key_reads_zero: assert property (rsp_r.rvalid && rdKey_r |-> rsp_r.rdata == '0)
      else $error("key register read returned nonzero");
   chk_refresh_loads: assert property (refreshSeq |-> loadedSeq)
      else $error("refresh did not load reload value");
   chk_reload_locked: assert property (doWrite && wrSel == SEL_RELOAD && !unlocked_r && !standbyReset
         |=> $stable(reload_r))
      else $error("locked reload register changed");
   chk_start_enables: assert property (startKey |=> kEnable_r)
      else $error("start key did not enable dog");
   chk_hw_option_runs: assert property (hwSync_r |=> kEnable_r)
      else $error("hardware option did not run dog");
   chk_zero_fires: assert property (kTick && kCount_r == 8'h00 |=> keyDogResetReq ##1 !lsRise [*1])
      else $error("key dog did not fire at zero");
   chk_enable_sticky: assert property (wEnable_r |=> wEnable_r)
      else $error("windowed enable cleared without reset");
   chk_window_fire: assert property (wEnable_r && wTick && !ctrlWr && wCount_r == WFIRE_AT
         |=> winDogResetReq && wCount_r == 7'h3f)
      else $error("windowed dog missed 0x40 to 0x3f");
   chk_disabled_quiet: assert property (!wEnable_r && !ctrlWr |=> !winDogResetReq)
      else $error("windowed reset while disabled");
   chk_early_reload: assert property (ctrlWr && wEnable_r && wCount_r > window_r |=> winDogResetReq)
      else $error("early reload did not reset");

   // ----------------------------------------
   // key, counter and bus checks
   // ----------------------------------------
   chk_unlock_opens: assert property (unlockKey && !standbyReset |=> unlocked_r)
      else $error("unlock key did not open access");
   chk_psc_locked: assert property (doWrite && wrSel == SEL_PSC && !unlocked_r |=> $stable(psc_r))
      else $error("locked prescaler register changed");
   chk_refresh_relocks: assert property (refreshKey && !standbyReset |=> !unlocked_r)
      else $error("refresh key did not restore protection");
   chk_standby_clears: assert property (standbyReset |=> !unlocked_r && reload_r == RELOAD_RST)
      else $error("standby reset left key state");
   chk_psc_write: assert property (pscWr && !standbyReset |=> psc_r == wData_r[2:0])
      else $error("unlocked prescaler write lost");
   chk_reload_write: assert property (reloadWr && !standbyReset |=> reload_r == wData_r[7:0])
      else $error("unlocked reload write lost");

   chk_fire_reloads: assert property (kFire |=> kCount_r == $past(reload_r))
      else $error("key dog did not reload after firing");
   chk_tick_decrement: assert property (kTick && !refreshKey && kCount_r != 8'h00
         |=> kCount_r == $past(kCount_r) - 8'h01)
      else $error("key counter did not step down by one");
   chk_key_start_cause: assert property ($rose(kEnable_r) |-> $past(startKey) || $past(hwSync_r))
      else $error("key dog started without cause");
   chk_key_req_held: assert property (keyDogResetReq && !lsRise |=> keyDogResetReq)
      else $error("key dog request dropped early");

   chk_win_decrement: assert property (wTick && !ctrlWr |=> wCount_r == $past(wCount_r) - 7'h01)
      else $error("windowed counter did not step down");
   chk_ctrl_load: assert property (ctrlWr |=> wCount_r == wData_r[6:0])
      else $error("control write did not load counter");
   chk_window_load: assert property (windowWr |=> window_r == wData_r[6:0])
      else $error("window write did not load value");
   chk_win_set_cause: assert property ($rose(wEnable_r) |-> $past(ctrlWr) && wData_r[WEN_BIT])
      else $error("windowed enable set without write");
   chk_win_req_cause: assert property (winDogResetReq |-> $past(wFire))
      else $error("windowed request without cause");

   chk_write_answers: assert property (doWrite |=> rsp_r.bvalid)
      else $error("write got no response");
   chk_read_answers: assert property (arTake |=> rsp_r.rvalid)
      else $error("read got no response");
   chk_bresp_holds: assert property (rsp_r.bvalid && !axiReq.bready
         |=> rsp_r.bvalid && $stable(rsp_r.bresp))
      else $error("write response dropped before handshake");
   chk_rdata_holds: assert property (rsp_r.rvalid && !axiReq.rready
         |=> rsp_r.rvalid && $stable(rsp_r.rdata))
      else $error("read data dropped before handshake");
   chk_write_slverr: assert property (doWrite && wrSel == SEL_NONE |=> rsp_r.bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_read_slverr: assert property (arTake && rdSel == SEL_NONE
         |=> rsp_r.rresp == RESP_SLVERR && rsp_r.rdata == '0)
      else $error("unmapped read not refused");
endmodule

// [dv/dual_watchdog_registers_tb.sv]
module dual_watchdog_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dual_watchdog_pkg::*;

   // ----------------------------------------
   // signals and scoreboard
   // ----------------------------------------
   localparam int WDIV_TB = 8;
   logic        clk           = 1'b0;
   logic        lowSpeedClock = 1'b0;
   logic        keyPrev       = 1'b0;
   logic [2:0]  lsDiv         = 3'h0;
   logic        rstn;
   logic        standbyReset;
   logic        hwDogSelect;
   logic        keyDogResetReq;
   logic        winDogResetReq;
   axiReq_t     req;
   axiRsp_t     rsp;
   logic [1:0]  expB[$];
   logic [65:0] expR[$];
   logic [65:0] eR;
   logic [31:0] rv;
   int          n_fail   = 0;
   int          compares = 0;
   int          cyc      = 0;
   int          keyFires = 0;
   int          winFires = 0;
   int          keyAt    = 0;
   int          winAt    = 0;
   int          t;
   int          k0;

   dual_watchdog_registers #(.WDIV(WDIV_TB)) dual_watchdog_registers_i (
      .clk(clk), .rstn(rstn), .standbyReset(standbyReset),
      .axiReq(req), .axiRsp(rsp),
      .lowSpeedClock(lowSpeedClock), .hwDogSelect(hwDogSelect),
      .keyDogResetReq(keyDogResetReq), .winDogResetReq(winDogResetReq)
   );

   // ----------------------------------------
   // clocks
   // ----------------------------------------
   always #2 clk = ~clk;

   // low-speed clock, eight master cycles a period
   always @(posedge clk) begin
      lsDiv <= lsDiv + 3'h1;
      lowSpeedClock <= lsDiv[2];
   end

   // ----------------------------------------
   // compare tasks and closing
   // ----------------------------------------
   task automatic chkEq(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkWin(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic complete_run();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // output monitor
   // ----------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      keyPrev <= keyDogResetReq;
      if (keyDogResetReq === 1'b1 && keyPrev !== 1'b1) begin
         keyFires <= keyFires + 1;
         keyAt <= cyc;
      end
      if (winDogResetReq === 1'b1) begin
         winFires <= winFires + 1;
         winAt <= cyc;
      end
      if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
         chkEq({30'h0, rsp.bresp}, {30'h0, expB.pop_front()});
      if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
         eR = expR.pop_front();
         chkEq(rsp.rdata & eR[65:34], eR[33:2] & eR[65:34]);
         chkEq({30'h0, rsp.rresp}, {30'h0, eR[1:0]});
      end
   end

   // ----------------------------------------
   // bus and helper tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge clk);
      expB.push_back(er);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= s;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m, input logic [1:0] er);
      @(posedge clk);
      expR.push_back({m, ex, er});
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
   endtask

   task automatic key(input logic [15:0] k);
      wr(OFS_KEY, {16'h0, k}, 4'h3, RESP_OKAY);
   endtask

   task automatic doReset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      standbyReset = 1'b0;
      hwDogSelect = 1'b0;
      req = '0;
      void'($urandom(68429));
      doReset();
      rd(OFS_CTRL, 32'h7f, 32'hffffffff, RESP_OKAY);
      rd(OFS_WINDOW, 32'h7f, 32'hffffffff, RESP_OKAY);
      rd(OFS_KEY, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(OFS_PSC, 32'h6, 32'hffffffff, RESP_OKAY);
      rd(OFS_RELOAD, 32'hff, 32'hffffffff, RESP_OKAY);
      rd(8'h0c, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(8'h18, 32'h1, 4'hf, RESP_SLVERR);
      wr(OFS_PSC, 32'h2, 4'hf, RESP_OKAY);
      rd(OFS_PSC, 32'h6, 32'hffffffff, RESP_OKAY);
      wr(OFS_RELOAD, 32'h33, 4'hf, RESP_OKAY);
      rd(OFS_RELOAD, 32'hff, 32'hffffffff, RESP_OKAY);
      key(KEY_UNLOCK);
      for (int c = 0; c < 7; c++) begin
         wr(OFS_PSC, 32'(c), 4'hf, RESP_OKAY);
         rd(OFS_PSC, 32'(c), 32'hffffffff, RESP_OKAY);
      end
      rv = 32'($urandom) & 32'h0000_00ff;
      wr(OFS_RELOAD, rv, 4'hf, RESP_OKAY);
      rd(OFS_RELOAD, rv, 32'hffffffff, RESP_OKAY);
      rd(OFS_KEY, 32'h0, 32'hffffffff, RESP_OKAY);
      key(KEY_REFRESH);
      wr(OFS_RELOAD, 32'h12, 4'hf, RESP_OKAY);
      rd(OFS_RELOAD, rv, 32'hffffffff, RESP_OKAY);
      key(KEY_UNLOCK);
      wr(OFS_RELOAD, 32'h5a, 4'hf, RESP_OKAY);
      @(posedge clk);
      standbyReset <= 1'b1;
      @(posedge clk);
      standbyReset <= 1'b0;
      rd(OFS_RELOAD, 32'hff, 32'hffffffff, RESP_OKAY);
      rd(OFS_KEY, 32'h0, 32'hffffffff, RESP_OKAY);
      wr(OFS_KEY, 32'h5555, 4'h1, RESP_OKAY);
      wr(OFS_RELOAD, 32'h21, 4'hf, RESP_OKAY);
      rd(OFS_RELOAD, 32'hff, 32'hffffffff, RESP_OKAY);
      $display("test registers done");

      doReset();
      key(KEY_UNLOCK);
      wr(OFS_PSC, 32'h0, 4'hf, RESP_OKAY);
      wr(OFS_RELOAD, 32'h2, 4'hf, RESP_OKAY);
      key(KEY_REFRESH);
      k0 = keyFires;
      repeat (150) @(posedge clk);
      chkEq(32'(keyFires - k0), 32'h0);
      key(KEY_START);
      for (int i = 0; i < 6; i++) begin
         repeat (40) @(posedge clk);
         key(KEY_REFRESH);
      end
      chkEq(32'(keyFires - k0), 32'h0);
      t = cyc;
      repeat (130) @(posedge clk);
      chkWin(keyAt - t, 55, 125);
      $display("test key dog done");

      doReset();
      hwDogSelect <= 1'b1;
      key(KEY_UNLOCK);
      wr(OFS_PSC, 32'h0, 4'hf, RESP_OKAY);
      wr(OFS_RELOAD, 32'h2, 4'hf, RESP_OKAY);
      key(KEY_REFRESH);
      t = cyc;
      repeat (130) @(posedge clk);
      chkWin(keyAt - t, 55, 125);
      hwDogSelect <= 1'b0;
      $display("test hardware option done");

      doReset();
      k0 = winFires;
      wr(OFS_CTRL, 32'h3f, 4'hf, RESP_OKAY);
      rd(OFS_CTRL, 32'h0, 32'hffffff80, RESP_OKAY);
      repeat (50) @(posedge clk);
      chkEq(32'(winFires - k0), 32'h0);
      wr(OFS_CTRL, 32'hff, 4'hf, RESP_OKAY);
      rd(OFS_CTRL, 32'h80, 32'hffffff80, RESP_OKAY);
      wr(OFS_CTRL, 32'h7f, 4'hf, RESP_OKAY);
      t = cyc;
      rd(OFS_CTRL, 32'h80, 32'hffffff80, RESP_OKAY);
      chkEq(32'(winFires - k0), 32'h0);
      repeat (560) @(posedge clk);
      chkWin(winAt - t, 485, 520);
      chkEq(32'(winFires - k0), 32'h1);
      $display("test windowed timeout done");

      doReset();
      wr(OFS_WINDOW, 32'h50, 4'hf, RESP_OKAY);
      rd(OFS_WINDOW, 32'h50, 32'hffffffff, RESP_OKAY);
      wr(OFS_CTRL, 32'hff, 4'hf, RESP_OKAY);
      t = cyc;
      repeat (5) @(posedge clk);
      chkWin(winAt - t, -4, 2);
      $display("test windowed early reload done");
      complete_run();
   end

   // ----------------------------------------
   // hang guard
   // ----------------------------------------
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule
